/* src/pcbc_top.sv */
// Bus cycle timing, decode, translation, dividers and timers
// What this block does
// RULE1: Timing machine restarts at every bus cycle start
// RULE2: Master holds cycle until acknowledge arrives
// RULE3: Acknowledge merges timing, decode, memory, bus acks
// RULE4: Decode uses raw untranslated address directly
// RULE5: Translate virtual to physical, check segment permission
// RULE6: Table 2K by 28 bits, one wait
// RULE7: Separate table halves for processor and DMA
// RULE8: Violation latches error register, raises interrupt
// RULE9: Processor reads, writes table and error register
// RULE10: DRAM one wait, five on refresh collision
// RULE11: Two DRAM banks, parity written and checked
// RULE12: Boot, identity, firmware memories take three waits
// RULE13: Two firmware banks, boot loader picks executable
// RULE14: DMA takes bus, translated, byte and word
// RULE15: Aligned 32/16/8 MHz, 1.28 MHz, 71.1 kHz
// RULE16: Two timer units, three 16-bit counters each
// RULE17: First unit makes baud clocks, third unused
// RULE18: Second unit ticks interrupt every 10 ms
// RULE19: Second unit counters two, three chain sanity
// RULE20: Timer accesses take four wait states
// RULE21: Violation interrupt at priority level five
// RULE22: Periodic tick interrupt at priority level three
// RULE23: DRAM read parity error interrupts level six
// RULE24: Waits counted in 16 MHz bus clocks
`default_nettype none
module pcbc_top
  import pcbc_pkg::*;
#(
  parameter int unsigned TICK_RELOAD = TICK_COUNT
) (
  input  wire logic              clk_i,
  input  wire logic              arst_n_i,
  input  wire logic              cpu_req_i,
  input  wire pcbc_req_t         cpu_i,
  input  wire logic              dma_req_i,
  input  wire pcbc_req_t         dma_i,
  input  wire logic              abus_ack_i,
  input  wire logic [31:0]       ext_rdata_i,
  input  wire logic [31:0]       mem_rdata_i,
  input  wire logic [3:0]        mem_par_i,
  input  wire logic              irq_ack_i,
  input  wire logic [2:0]        irq_ack_level_i,
  output logic                   cpu_ack_o,
  output logic                   abus_ack_o,
  output logic [31:0]            rdata_o,
  output logic                   mem_cs_o,
  output logic                   mem_bank_o,
  output logic                   mem_we_o,
  output logic [3:0]             mem_be_o,
  output logic [PHYS_W-1:0]      mem_addr_o,
  output logic [31:0]            mem_wdata_o,
  output logic [3:0]             mem_par_o,
  output logic                   refresh_o,
  output logic                   boot_cs_o,
  output logic                   idrom_cs_o,
  output logic                   fw_cs_o,
  output logic                   fw_bank_o,
  output logic                   abus_cs_o,
  output logic [2:0]             irq_level_o,
  output logic                   baud0_o,
  output logic                   baud1_o,
  output logic                   sanity_clk_o,
  output logic                   clk32_en_o,
  output logic                   clk16_en_o,
  output logic                   clk8_en_o,
  output logic                   clk1m28_en_o,
  output logic                   clk71k_en_o
);
  if (TICK_RELOAD < 2 || TICK_RELOAD > 65536) begin : g_chk
    $error("TICK_RELOAD must fit a 16-bit counter");
  end

  localparam logic [8:0]  ACC_STEP  = 9'(PLL_MHZ);
  localparam logic [8:0]  ACC_MOD   = 9'(SYS_MHZ);
  localparam logic [4:0]  D25_LAST  = 5'(DIV_1M28 - 1);
  localparam logic [8:0]  D450_LAST = 9'(DIV_71K - 1);
  localparam logic [7:0]  RFSH_LAST = 8'(REFRESH_TICKS - 1);
  localparam logic [15:0] TICK_RLD  = 16'(TICK_RELOAD - 1);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_RUN = 2'b01, ST_ACK = 2'b10
  } pcbc_state_t;

  function automatic pcbc_region_t region_of(input logic [31:0] a);
    unique case (a[REGION_LSB +: 4])
      4'h0:    region_of = RG_DRAM;
      4'h1:    region_of = RG_BOOT;
      4'h2:    region_of = RG_IDROM;
      4'h3:    region_of = RG_FW;
      4'h4:    region_of = RG_MMU;
      4'h5:    region_of = RG_MERR;
      4'h6:    region_of = RG_TMR;
      4'h7:    region_of = RG_FWSEL;
      default: region_of = RG_EXT;
    endcase
  endfunction : region_of

  function automatic logic [3:0] parity_of(input logic [31:0] d);
    for (int b = 0; b < 4; b++) begin
      parity_of[b] = ^d[8*b +: 8];
    end
  endfunction : parity_of

  function automatic logic [2:0] tmr_index(input logic [31:0] a);
    tmr_index = 3'(a[TMR_SEL_LSB +: 2]);
    if (a[TMR_UNIT_BIT]) begin
      tmr_index = tmr_index + 3'h3;
    end
    // Slot 3 of either unit is empty and must not alias a live counter
    if (a[TMR_SEL_LSB +: 2] == 2'h3) begin
      tmr_index = 3'(TMR_NUM);
    end
  endfunction : tmr_index

  // ---------------- Clock dividers
  logic [8:0] acc_q;
  logic [1:0] ph_q;
  logic [4:0] d25_q;
  logic [8:0] d450_q;
  logic       en32_q, en16_q, en8_q, en1m28_q, en71k_q;
  wire  [8:0] acc_sum  = acc_q + ACC_STEP;
  wire        acc_wrap = acc_sum >= ACC_MOD;

  // Fractional accumulator: 200 MHz is no integer multiple of 32 MHz,
  // so the 32 MHz enables jitter by one cycle but average exactly.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      acc_q    <= '0;
      ph_q     <= '0;
      d25_q    <= '0;
      d450_q   <= '0;
      en32_q   <= 1'b0;
      en16_q   <= 1'b0;
      en8_q    <= 1'b0;
      en1m28_q <= 1'b0;
      en71k_q  <= 1'b0;
    end else begin
      acc_q    <= acc_wrap ? acc_sum - ACC_MOD : acc_sum;
      en32_q   <= acc_wrap;                                   // RULE15
      en16_q   <= acc_wrap && ph_q[0];                        // RULE15
      en8_q    <= acc_wrap && (ph_q == 2'h3);                 // RULE15
      en1m28_q <= acc_wrap && (d25_q == D25_LAST);            // RULE15
      en71k_q  <= acc_wrap && (d450_q == D450_LAST);          // RULE15
      if (acc_wrap) begin
        ph_q   <= ph_q + 2'h1;
        d25_q  <= (d25_q == D25_LAST) ? '0 : d25_q + 5'h1;
        d450_q <= (d450_q == D450_LAST) ? '0 : d450_q + 9'h1;
      end
    end
  end

  // ---------------- Cycle start, decode and translation
  pcbc_state_t  state_q;
  pcbc_req_t    cur_q;
  pcbc_region_t region_q;
  logic         dma_q, viol_q, coll_q, ack_q;
  logic [2:0]   waits_q, ticks_q;
  logic [31:0]  rdata_q;
  logic [ENTRY_W-1:0] mmu_mem [MMU_DEPTH];

  // DMA seizes the local bus over the processor
  wire           start   = (state_q == ST_IDLE) && (cpu_req_i || dma_req_i);
  wire           m_dma   = dma_req_i;                                // RULE14
  wire pcbc_req_t nreq   = m_dma ? dma_i : cpu_i;
  wire pcbc_region_t nreg = region_of(nreq.addr);                    // RULE4
  wire [MMU_IDX_W-1:0] xidx = {m_dma, nreq.addr[PAGE_LSB +: VPAGE_W]}; // RULE7
  wire [ENTRY_W-1:0] xent = mmu_mem[xidx];                           // RULE5
  wire           nviol   = (nreg == RG_DRAM) && (!xent[ENT_VALID] ||
                           (nreq.wr && !xent[ENT_WRITE]));           // RULE5
  wire [PHYS_W-1:0] nphys = {xent[PPAGE_W-1:0],
                             nreq.addr[PAGE_LSB-1:0]};               // RULE5
  wire           cur_req = dma_q ? dma_req_i : cpu_req_i;
  wire [MMU_IDX_W-1:0] tidx = cur_q.addr[TBL_IDX_LSB +: MMU_IDX_W];
  wire [2:0]     tsel    = tmr_index(cur_q.addr);

  logic rfsh_pend_q;
  wire  ncoll = (nreg == RG_DRAM) && rfsh_pend_q;

  logic [2:0] nwaits;
  always_comb begin
    unique case (nreg)
      RG_DRAM:                 nwaits = ncoll ? WS_DRAM_RFSH : WS_DRAM; // RULE10
      RG_BOOT, RG_IDROM, RG_FW: nwaits = WS_ROM;                     // RULE12
      RG_MMU:                  nwaits = WS_MMU;                      // RULE6
      RG_TMR:                  nwaits = WS_TMR;                      // RULE20
      default:                 nwaits = WS_REG;
    endcase
  end

  // Peripheral-bus targets also wait for the bus's own acknowledge
  wire timing_done = en16_q && (ticks_q == WS_BASE + waits_q);       // RULE24
  wire finish = (state_q == ST_RUN) && timing_done &&
                ((region_q != RG_EXT) || abus_ack_i);                // RULE3
  wire rd_dram = finish && (region_q == RG_DRAM) && !cur_q.wr && !viol_q;
  wire par_err = rd_dram && (parity_of(mem_rdata_i) != mem_par_i);   // RULE11

  // ---------------- Timers
  logic [TMR_W-1:0] cnt_q [TMR_NUM];
  logic [TMR_W-1:0] rld_q [TMR_NUM];
  logic [TMR_NUM-1:0] zero, dec;
  wire  tmr_wr = finish && (region_q == RG_TMR) && cur_q.wr;
  logic fwbank_q;
  pcbc_err_t err_q;

  logic [31:0] rmux;
  always_comb begin
    unique case (region_q)
      RG_DRAM:  rmux = viol_q ? '0 : mem_rdata_i;
      RG_MMU:   rmux = {4'h0, mmu_mem[tidx]};                        // RULE9
      RG_MERR:  rmux = err_q;                                        // RULE9
      RG_TMR:   rmux = (tsel < 3'(TMR_NUM)) ? {16'h0000, cnt_q[tsel]} : '0;
      RG_FWSEL: rmux = {31'h0000_0000, fwbank_q};
      default:  rmux = ext_rdata_i;
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q  <= ST_IDLE;
      cur_q    <= '0;
      region_q <= RG_DRAM;
      dma_q    <= 1'b0;
      viol_q   <= 1'b0;
      coll_q   <= 1'b0;
      waits_q  <= '0;
      ticks_q  <= '0;
      ack_q    <= 1'b0;
      rdata_q  <= '0;
    end else begin
      unique case (state_q)
        ST_IDLE: if (start) begin
          state_q  <= ST_RUN;                                        // RULE1
          ticks_q  <= '0;                                            // RULE1
          cur_q    <= nreq;
          region_q <= nreg;
          dma_q    <= m_dma;
          viol_q   <= nviol;
          coll_q   <= ncoll;
          waits_q  <= nwaits;
        end
        ST_RUN: begin
          if (en16_q) begin
            ticks_q <= ticks_q + 3'h1;                               // RULE24
          end
          if (finish) begin
            ack_q   <= 1'b1;                                         // RULE3
            rdata_q <= rmux;
            state_q <= ST_ACK;
          end
        end
        ST_ACK: if (!cur_req) begin
          ack_q   <= 1'b0;                                           // RULE2
          state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Table memory has no reset; software loads it before enabling use
  always_ff @(posedge clk_i) begin
    if (finish && (region_q == RG_MMU) && cur_q.wr) begin
      mmu_mem[tidx] <= cur_q.wdata[ENTRY_W-1:0];                     // RULE9
    end
  end

  // ---------------- Memory strobes, chip selects, refresh
  logic [7:0] rfsh_cnt_q;
  logic       mem_cs_q, bank_q, we_q, rfsh_q;
  logic       boot_q, idrom_q, fw_q, abus_q;
  logic [3:0] be_q, par_q;
  logic [PHYS_W-1:0] maddr_q;
  logic [31:0] wdata_q;
  wire        cyc_end = (state_q == ST_ACK) && !cur_req;
  wire        rfsh_due  = en16_q && (rfsh_cnt_q == RFSH_LAST);
  wire        rfsh_take = rfsh_pend_q && (ncoll && start ||
                          state_q == ST_IDLE && !start);
  logic [3:0] nbe;
  always_comb begin
    unique case (nreq.size)
      SZ_BYTE: nbe = 4'(4'h1 << nreq.addr[1:0]);                     // RULE14
      SZ_WORD: nbe = nreq.addr[1] ? 4'hc : 4'h3;                     // RULE14
      default: nbe = 4'hf;
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      {mem_cs_q, bank_q, we_q, rfsh_q} <= '0;
      {boot_q, idrom_q, fw_q, abus_q}  <= '0;
      be_q       <= '0;
      par_q      <= '0;
      maddr_q    <= '0;
      wdata_q    <= '0;
      rfsh_cnt_q <= '0;
      rfsh_pend_q <= 1'b0;
      fwbank_q   <= 1'b0;
    end else begin
      if (start) begin
        mem_cs_q <= (nreg == RG_DRAM) && !nviol;
        bank_q   <= nphys[DRAM_BANK_BIT];                            // RULE11
        maddr_q  <= nphys;
        we_q     <= nreq.wr;
        be_q     <= nbe;
        wdata_q  <= nreq.wdata;
        par_q    <= parity_of(nreq.wdata);                           // RULE11
        boot_q   <= nreg == RG_BOOT;
        idrom_q  <= nreg == RG_IDROM;
        fw_q     <= nreg == RG_FW;
        abus_q   <= nreg == RG_EXT;
      end else if (cyc_end) begin
        {mem_cs_q, boot_q, idrom_q, fw_q, abus_q} <= '0;
      end
      if (finish && (region_q == RG_FWSEL) && cur_q.wr) begin
        fwbank_q <= cur_q.wdata[0];                                  // RULE13
      end
      // Refresh rides along a colliding access or takes an idle cycle with no start
      if (en16_q) begin
        rfsh_cnt_q <= rfsh_due ? '0 : rfsh_cnt_q + 8'h1;
      end
      // A newly due refresh stays pending even while the old one is taken
      rfsh_q      <= rfsh_take;                                      // RULE10
      rfsh_pend_q <= rfsh_due || (rfsh_pend_q && !rfsh_take);
    end
  end

  for (genvar i = 0; i < TMR_NUM; i++) begin : g_tmr
    localparam logic [15:0] RST = (i == 3) ? TICK_RLD : 16'hffff;
    // Unit one counter three stays idle; unit two counter three chains
    if (i == 2) begin : g_off
      assign dec[i] = 1'b0;                                          // RULE17
    end else if (i == 5) begin : g_chain
      assign dec[i] = zero[4];                                       // RULE19
    end else begin : g_free
      assign dec[i] = en1m28_q;                                      // RULE16
    end
    assign zero[i] = dec[i] && (cnt_q[i] == '0);
    always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        cnt_q[i] <= RST;
        rld_q[i] <= RST;
      end else if (tmr_wr && tsel == 3'(i)) begin
        cnt_q[i] <= cur_q.wdata[TMR_W-1:0];
        rld_q[i] <= cur_q.wdata[TMR_W-1:0];
      end else if (dec[i]) begin
        cnt_q[i] <= zero[i] ? rld_q[i] : cnt_q[i] - 16'h0001;        // RULE16
      end
    end
  end

  // ---------------- Error latch and interrupts
  logic pend_par_q, pend_mmu_q, pend_tick_q, baud0_q, baud1_q, san_q;
  logic [2:0] irq_q;
  wire  viol_ev = start && nviol;
  wire  clr_par  = irq_ack_i && irq_ack_level_i == IRQ_PARITY;
  wire  clr_mmu  = irq_ack_i && irq_ack_level_i == IRQ_MMU;
  wire  clr_tick = irq_ack_i && irq_ack_level_i == IRQ_TICK;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      err_q       <= '0;
      {pend_par_q, pend_mmu_q, pend_tick_q} <= '0;
      {baud0_q, baud1_q, san_q} <= '0;
      irq_q       <= IRQ_NONE;
    end else begin
      if (viol_ev) begin
        err_q <= '{dma: m_dma, wr: nreq.wr, vaddr: nreq.addr[29:0]}; // RULE8
      end
      // Set wins over an acknowledge in the same cycle
      pend_par_q  <= par_err  || (pend_par_q  && !clr_par);          // RULE23
      pend_mmu_q  <= viol_ev  || (pend_mmu_q  && !clr_mmu);          // RULE8
      pend_tick_q <= zero[3]  || (pend_tick_q && !clr_tick);         // RULE18
      baud0_q     <= baud0_q ^ zero[0];                              // RULE17
      baud1_q     <= baud1_q ^ zero[1];                              // RULE17
      san_q       <= san_q ^ zero[5];                                // RULE19
      irq_q       <= pend_par_q ? IRQ_PARITY :                       // RULE23
                     pend_mmu_q ? IRQ_MMU :                          // RULE21
                     pend_tick_q ? IRQ_TICK : IRQ_NONE;              // RULE22
    end
  end

  assign cpu_ack_o    = ack_q;
  assign abus_ack_o   = ack_q;
  assign rdata_o      = rdata_q;
  assign mem_cs_o     = mem_cs_q;
  assign mem_bank_o   = bank_q;
  assign mem_we_o     = we_q;
  assign mem_be_o     = be_q;
  assign mem_addr_o   = maddr_q;
  assign mem_wdata_o  = wdata_q;
  assign mem_par_o    = par_q;
  assign refresh_o    = rfsh_q;
  assign boot_cs_o    = boot_q;
  assign idrom_cs_o   = idrom_q;
  assign fw_cs_o      = fw_q;
  assign fw_bank_o    = fwbank_q;
  assign abus_cs_o    = abus_q;
  assign irq_level_o  = irq_q;
  assign baud0_o      = baud0_q;
  assign baud1_o      = baud1_q;
  assign sanity_clk_o = san_q;
  assign clk32_en_o   = en32_q;
  assign clk16_en_o   = en16_q;
  assign clk8_en_o    = en8_q;
  assign clk1m28_en_o = en1m28_q;
  assign clk71k_en_o  = en71k_q;

  // ---------------- Assertions
  sequence s_start;
    state_q == ST_IDLE && (cpu_req_i || dma_req_i);
  endsequence
  sequence s_running;
    state_q == ST_RUN && ticks_q == 3'h0;
  endsequence

  property p_restart;
    @(posedge clk_i) disable iff (!arst_n_i) s_start |=> s_running;
  endproperty
  a_restart: assert property (p_restart) else $error("no restart"); // RULE1

  property p_hold;
    @(posedge clk_i) disable iff (!arst_n_i)
      ack_q && cur_req |=> ack_q && cpu_ack_o == abus_ack_o;
  endproperty
  a_hold: assert property (p_hold) else $error("ack dropped"); // RULE2

  property p_ext;
    @(posedge clk_i) disable iff (!arst_n_i)
      $rose(ack_q) && region_q == RG_EXT |-> $past(abus_ack_i);
  endproperty
  a_ext: assert property (p_ext) else $error("ext ack early"); // RULE3

  property p_decode;
    @(posedge clk_i) disable iff (!arst_n_i)
      start && nreq.addr[31:28] == 4'h6 |=> region_q == RG_TMR
        && waits_q == WS_TMR;
  endproperty
  a_decode: assert property (p_decode) else $error("bad decode"); // RULE4

  property p_waits;
    @(posedge clk_i) disable iff (!arst_n_i)
      $rose(ack_q) |-> $past(ticks_q) == WS_BASE + waits_q;
  endproperty
  a_waits: assert property (p_waits) else $error("wait count"); // RULE24

  property p_coll;
    @(posedge clk_i) disable iff (!arst_n_i)
      start && ncoll |=> waits_q == WS_DRAM_RFSH ##0 refresh_o;
  endproperty
  a_coll: assert property (p_coll) else $error("refresh wait"); // RULE10

  property p_viol;
    @(posedge clk_i) disable iff (!arst_n_i)
      viol_ev |=> pend_mmu_q && err_q.vaddr == $past(nreq.addr[29:0])
        ##1 irq_level_o >= IRQ_MMU;
  endproperty
  a_viol: assert property (p_viol) else $error("violation lost"); // RULE8

  property p_par;
    @(posedge clk_i) disable iff (!arst_n_i)
      par_err |=> ##1 irq_level_o == IRQ_PARITY;
  endproperty
  a_par: assert property (p_par) else $error("parity irq"); // RULE23

  property p_tick;
    @(posedge clk_i) disable iff (!arst_n_i)
      zero[3] && !pend_par_q && !pend_mmu_q && !viol_ev && !par_err
        |=> ##1 irq_level_o == IRQ_TICK;
  endproperty
  a_tick: assert property (p_tick) else $error("tick irq"); // RULE22

  property p_div;
    @(posedge clk_i) disable iff (!arst_n_i)
      clk8_en_o |-> clk16_en_o && clk32_en_o;
  endproperty
  a_div: assert property (p_div) else $error("edges unaligned"); // RULE15

  property p_half;
    @(posedge clk_i) disable iff (!arst_n_i)
      start && m_dma |-> xidx[MMU_IDX_W-1];
  endproperty
  a_half: assert property (p_half) else $error("wrong half"); // RULE7
endmodule : pcbc_top
`default_nettype wire

/* shared/pcbc_pkg.sv */
// Constants and carrier types for the processor card bus cycle control
`default_nettype none
package pcbc_pkg;
  // Clocking: system clock and the rates derived from it
  localparam int unsigned SYS_MHZ     = 200;
  localparam int unsigned PLL_MHZ     = 32;
  localparam int unsigned BUS_MHZ     = 16;
  localparam int unsigned DIV_1M28    = 25;   // 32 MHz / 25
  localparam int unsigned DIV_71K     = 450;  // 32 MHz / 450
  localparam int unsigned TMR_KHZ     = 1280;
  localparam int unsigned TICK_MS     = 10;
  localparam int unsigned TICK_COUNT  = TMR_KHZ * TICK_MS;
  localparam int unsigned REFRESH_NS  = 15600;
  localparam int unsigned REFRESH_TICKS = REFRESH_NS * BUS_MHZ / 1000;

  // Wait states, in bus clocks beyond the base bus clock
  localparam logic [2:0] WS_BASE      = 3'h1;
  localparam logic [2:0] WS_DRAM      = 3'h1;
  localparam logic [2:0] WS_DRAM_RFSH = 3'h5;
  localparam logic [2:0] WS_ROM       = 3'h3;
  localparam logic [2:0] WS_MMU       = 3'h1;
  localparam logic [2:0] WS_TMR       = 3'h4;
  localparam logic [2:0] WS_REG       = 3'h1;

  // Address map: region code in the top nibble of the raw address
  localparam int unsigned REGION_LSB  = 28;
  typedef enum logic [3:0] {
    RG_DRAM  = 4'h0, RG_BOOT  = 4'h1, RG_IDROM = 4'h2, RG_FW    = 4'h3,
    RG_MMU   = 4'h4, RG_MERR  = 4'h5, RG_TMR   = 4'h6, RG_FWSEL = 4'h7,
    RG_EXT   = 4'hf
  } pcbc_region_t;

  // Translation table layout
  localparam int unsigned PAGE_LSB    = 12;
  localparam int unsigned VPAGE_W     = 10;
  localparam int unsigned PPAGE_W     = 11;
  localparam int unsigned PHYS_W      = PAGE_LSB + PPAGE_W;
  localparam int unsigned ENTRY_W     = 28;
  localparam int unsigned MMU_IDX_W   = 11;
  localparam int unsigned MMU_DEPTH   = 2048;
  localparam int unsigned ENT_VALID   = 11;
  localparam int unsigned ENT_WRITE   = 12;
  localparam int unsigned TBL_IDX_LSB = 2;
  localparam int unsigned DRAM_BANK_BIT = 22;

  // Timer addressing
  localparam int unsigned TMR_SEL_LSB = 2;
  localparam int unsigned TMR_UNIT_BIT = 4;
  localparam int unsigned TMR_NUM     = 6;
  localparam int unsigned TMR_W       = 16;

  // Interrupt priority levels
  localparam logic [2:0] IRQ_NONE     = 3'h0;
  localparam logic [2:0] IRQ_TICK     = 3'h3;
  localparam logic [2:0] IRQ_MMU      = 3'h5;
  localparam logic [2:0] IRQ_PARITY   = 3'h6;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0, SZ_WORD = 2'h1, SZ_LONG = 2'h2
  } pcbc_size_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        wr;
    pcbc_size_t  size;
  } pcbc_req_t;

  typedef struct packed {
    logic        dma;
    logic        wr;
    logic [29:0] vaddr;
  } pcbc_err_t;
endpackage : pcbc_pkg
`default_nettype wire

/* bench/pcbc_master.sv */
// Bus master model that opens cycles for the processor or a DMA card
`default_nettype none
module pcbc_master
  import pcbc_pkg::*;
(
  input  wire logic      clk_i,
  input  wire logic      go_i,
  input  wire logic      dma_sel_i,
  input  wire pcbc_req_t req_i,
  input  wire logic      ack_i,
  output var logic       busy_o,
  output logic           cpu_req_o,
  output logic           dma_req_o,
  output pcbc_req_t      cpu_o,
  output pcbc_req_t      dma_o
);
  timeunit 1ns;
  timeprecision 1ps;
  pcbc_req_t cur_q = '0;
  logic      sel_q = 1'b0;
  logic      busy_q = 1'b0;
  always @(posedge clk_i) begin
    if (go_i && !busy_q) begin
      busy_q <= 1'b1;
      cur_q  <= req_i;
      sel_q  <= dma_sel_i;
    end else if (ack_i) begin
      busy_q <= 1'b0;
    end
  end
  assign busy_o = busy_q;
  // A master that has let go shows inverted lines, never a stale cycle
  assign cpu_req_o = busy_q & ~sel_q;
  assign dma_req_o = busy_q & sel_q;
  assign cpu_o = pcbc_req_t'(cpu_req_o ? cur_q : ~cur_q);
  assign dma_o = pcbc_req_t'(dma_req_o ? cur_q : ~cur_q);
endmodule : pcbc_master
`default_nettype wire

/* bench/tb_top.sv */
// Self-checking bench for the bus cycle control block
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
  mismatches++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module tb_top import pcbc_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, arst_n_i, go, dsel, irq_ack_i, abus_ack_i, busy, par_bad;
  logic ack_d = 1'b0;
  logic bank_seen;
  logic [2:0]  irq_ack_level_i;
  logic [31:0] ext_rdata_i, mem_rdata_i, md, r;
  logic [3:0]  mem_par_i = '0;
  logic [3:0]  be_seen;
  logic [32:0] e;
  logic [32:0] expq[$];
  logic [27:0] ent;
  logic [10:0] pg;
  logic [PHYS_W-1:0] addr_seen;
  pcbc_req_t   req, cpu_i, dma_i;
  pcbc_size_t  sz;
  wire cpu_req_i, dma_req_i, cpu_ack_o, abus_ack_o, mem_cs_o, mem_we_o;
  wire fw_bank_o, mem_bank_o;
  wire [31:0] rdata_o;
  wire [3:0]  mem_be_o, mem_par_o;
  wire [2:0]  irq_level_o;
  wire [PHYS_W-1:0] mem_addr_o;
  int mismatches, checks_done, cyc, n, k;

  pcbc_top #(.TICK_RELOAD(20)) uut (.clk_i, .arst_n_i, .cpu_req_i, .cpu_i,
    .dma_req_i, .dma_i, .abus_ack_i, .ext_rdata_i, .mem_rdata_i,
    .mem_par_i(mem_par_i ^ {3'h0, par_bad}),
    .irq_ack_i, .irq_ack_level_i, .cpu_ack_o, .abus_ack_o, .rdata_o,
    .mem_cs_o, .mem_bank_o, .mem_we_o, .mem_be_o, .mem_addr_o,
    .mem_wdata_o(), .mem_par_o, .refresh_o(), .boot_cs_o(), .idrom_cs_o(),
    .fw_cs_o(), .fw_bank_o, .abus_cs_o(), .irq_level_o, .baud0_o(),
    .baud1_o(), .sanity_clk_o(), .clk32_en_o(), .clk16_en_o(),
    .clk8_en_o(), .clk1m28_en_o(), .clk71k_en_o());
  pcbc_master master (.clk_i, .go_i(go), .dma_sel_i(dsel), .req_i(req),
    .ack_i(cpu_ack_o), .busy_o(busy), .cpu_req_o(cpu_req_i),
    .dma_req_o(dma_req_i), .cpu_o(cpu_i), .dma_o(dma_i));

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop

  task automatic xfer(input logic d, input logic [31:0] a, input logic w,
    input logic [31:0] wd, input logic [31:0] x, input int wl, input int wh);
    int c;
    c = 0;
    req <= '{addr: a, wdata: wd, wr: w, size: sz};
    dsel <= d;
    go <= 1'b1;
    expq.push_back({~w, x});
    @(posedge clk_i);
    go <= 1'b0;
    while (!cpu_ack_o && c < 400) begin
      @(posedge clk_i);
      c++;
    end
    `CHK("latency", 1'b1, c >= (1+wl)*12+2 && c <= (2+wh)*13+4)
    while (cpu_ack_o) @(posedge clk_i);
  endtask : xfer

  task automatic irq_ack(input logic [2:0] l);
    irq_ack_i <= 1'b1;
    irq_ack_level_i <= l;
    @(posedge clk_i);
    irq_ack_i <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask : irq_ack

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cyc++;
    if (cyc > 20000) begin
      mismatches++;
      report_and_stop();
    end
  end

  always @(posedge clk_i) begin
    if (cpu_ack_o && !ack_d) begin
      e = expq.pop_front();
      if (e[32]) `CHK("rdata", e[31:0], rdata_o)
      `CHK("abus_ack", 1'b1, abus_ack_o)
    end
    ack_d <= cpu_ack_o;
    // Parity RAM keeps what the block generated on the last write
    if (mem_cs_o && mem_we_o) begin
      mem_par_i <= mem_par_o;
      addr_seen <= mem_addr_o;
      be_seen <= mem_be_o;
      bank_seen <= mem_bank_o;
    end
  end

  initial begin
    {arst_n_i, go, dsel, irq_ack_i, par_bad} = '0;
    irq_ack_level_i = 3'h0;
    abus_ack_i = 1'b1;
    req = '0;
    sz = SZ_LONG;
    void'($urandom(69063));
    md = $urandom;
    mem_rdata_i = md;
    ext_rdata_i = $urandom;
    pg = 11'($urandom);
    ent = {15'($urandom), 2'b11, pg};
    repeat (12) @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(posedge clk_i);
    for (k = 0; k < 2; k++) begin
      n = 0;
      while (irq_level_o !== IRQ_TICK && n < 4000) begin
        @(posedge clk_i);
        n++;
      end
      irq_ack(IRQ_TICK);
    end
    `CHK("tick_period", 1'b1, n > 2900 && n < 3300)
    xfer(0, 32'h4000_0000, 1, {4'h0, ent}, 0, 1, 1);
    xfer(0, 32'h4000_0000, 0, 0, {4'h0, ent}, 1, 1);
    xfer(0, 32'h4000_0004, 1, 0, 0, 1, 1);
    xfer(0, 32'h4000_1000, 1, {19'h3, ~pg}, 0, 1, 1);
    xfer(0, 32'h0000_0010, 1, md, 0, 1, 5);
    `CHK("phys", {pg, 12'h010}, addr_seen)
    `CHK("bank", pg[10], bank_seen)
    xfer(0, 32'h0000_0010, 0, 0, md, 1, 5);
    `CHK("par_ok", 1'b1, irq_level_o !== IRQ_PARITY)
    xfer(0, 32'h0000_1000, 0, 0, 0, 1, 5);
    `CHK("mmu_irq", IRQ_MMU, irq_level_o)
    xfer(0, 32'h5000_0000, 0, 0, 32'h0000_1000, 1, 1);
    irq_ack(IRQ_MMU);
    `CHK("mmu_clr", 1'b1, irq_level_o !== IRQ_MMU)
    par_bad <= 1'b1;
    xfer(0, 32'h0000_0010, 0, 0, md, 1, 5);
    `CHK("par_irq", IRQ_PARITY, irq_level_o)
    irq_ack(IRQ_PARITY);
    sz = SZ_BYTE;
    xfer(1, 32'h0000_0003, 1, md, 0, 1, 5);
    `CHK("dma_phys", {~pg, 12'h003}, addr_seen)
    `CHK("dma_be", 4'h8, be_seen)
    sz = SZ_LONG;
    xfer(0, 32'h1000_0000, 0, 0, ext_rdata_i, 3, 3);
    xfer(0, 32'h7000_0000, 1, 1, 0, 1, 1);
    `CHK("fw_bank", 1'b1, fw_bank_o)
    r = {16'h0, 16'($urandom)};
    xfer(0, 32'h6000_0008, 1, r, 0, 4, 4);
    xfer(0, 32'h6000_0008, 0, 0, r, 4, 4);
    xfer(0, 32'h6000_000C, 0, 0, 0, 4, 4);
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
